// ===== src/rac_averager.sv
// Reading averager with input FIFO, resolution and AC bandwidth settings
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module rac_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      level;
   logic             push;
   logic             pop;

   assign in_ready  = (level != (AW+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         level <= '0;
      end else if (push && !pop) begin
         level <= level + 1'b1;
      end else if (pop && !push) begin
         level <= level - 1'b1;
      end
   end
endmodule // rac_fifo

module rac_averager
   import rac_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   // Register port
   input  wire logic [2:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   // Readings from converter
   input  wire logic              rdg_valid,
   output logic                   rdg_ready,
   input  wire logic [RD_W-1:0]   rdg_data,
   // Readings to display
   output logic                   avg_valid,
   output logic      [RD_W-1:0]   avg_data,
   // Panel buttons and remote reset
   input  wire logic              filter_btn,
   input  wire logic              digits_btn,
   input  wire logic              remote_reset,
   // Settings out
   output logic                   filter_active_indicator,
   output rac_bw_type             ac_bw_sel,
   output rac_res_type            display_res,
   output rac_res_type            conv_res,
   output logic                   auto_zero_en,
   output rac_nplc_type           nplc_sel
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   logic                 cfg_en;
   logic                 cfg_mode;
   logic [6:0]           cfg_count;
   rac_func_type         meas_func;
   rac_res_type          res_mem [NFUNC];
   rac_res_type          res_cur;
   logic [1:0]           btn_raw;
   logic [1:0]           btn_evt;
   logic                 fifo_valid;
   logic                 fifo_ready;
   logic [RD_W-1:0]      fifo_data;
   logic                 pop;
   logic                 filter_active_indicator_on;
   logic                 ctrl_wr;
   logic                 clear_avg;
   logic [6:0]           wr_count;
   logic                 div_start;
   logic                 div_last;
   rac_state_type        state;
   logic [RD_W-1:0]      sample_buf [DEPTH];
   logic [6:0]           wr_idx;
   logic [6:0]           fill;
   logic [SUM_W-1:0]     run_sum;
   logic [SUM_W-1:0]     new_ext;
   logic [SUM_W-1:0]     old_ext;
   logic [SUM_W-1:0]     next_sum;
   logic [6:0]           next_fill;
   logic [SUM_W-1:0]     div_quo;
   logic [7:0]           div_rem;
   logic [7:0]           rem_sh;
   logic                 q_bit;
   logic [5:0]           div_step;
   logic [6:0]           div_den;
   logic                 div_neg;
   logic [SUM_W-1:0]     quo_fin;
   logic [SUM_W-1:0]     result;
   logic [31:0]          read_word;
   logic                 div_cut;

   // Button pins: three-stage sync, press counted when stages two and three agree
   assign btn_raw = {digits_btn, filter_btn};
   for (genvar g = 0; g < 2; g++) begin : g_btn
      logic [2:0] sync;
      logic       level;
      logic       evt;
      always_ff @(posedge ref_clk) begin
         if (!resetn) begin
            sync  <= 3'h0;
            level <= 1'b0;
            evt   <= 1'b0;
         end else begin
            sync  <= {sync[1:0], btn_raw[g]};
            evt   <= (sync[1] == sync[2]) && sync[1] && !level;
            if (sync[1] == sync[2]) begin
               level <= sync[1];
            end
         end
      end
      assign btn_evt[g] = evt;
   end

   // Filter configuration
   assign ctrl_wr  = reg_wr && (reg_addr == ADDR_CTRL);
   assign wr_count = clamp_count(reg_wdata[CTRL_CNT +: 7]);
   assign clear_avg = btn_evt[0]
                    || (ctrl_wr && ((reg_wdata[CTRL_EN] != cfg_en) || (reg_wdata[CTRL_MODE] != cfg_mode)
                                    || (wr_count != cfg_count)))
                    || (reg_wr && (reg_addr == ADDR_FUNC) && (reg_wdata[3:0] != meas_func));

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cfg_en    <= 1'b1;
         cfg_mode  <= 1'b0;
         cfg_count <= CNT_RST;
      end else if (btn_evt[0]) begin
         cfg_en <= !cfg_en;
      end else if (ctrl_wr) begin
         cfg_en    <= reg_wdata[CTRL_EN];
         cfg_mode  <= reg_wdata[CTRL_MODE];
         cfg_count <= wr_count;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         meas_func <= FN_DCV;
         ac_bw_sel <= BW_MED;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_FUNC && reg_wdata[3:0] < 4'(NFUNC)) begin
            meas_func <= rac_func_type'(reg_wdata[3:0]);
         end
         if (reg_addr == ADDR_ACBW && reg_wdata[1:0] != 2'h3) begin
            ac_bw_sel <= rac_bw_type'(reg_wdata[1:0]);
         end
      end
   end

   // Per-function resolution store
   assign res_cur = res_mem[meas_func];
   always_ff @(posedge ref_clk) begin
      if (!resetn || remote_reset) begin
         for (int i = 0; i < NFUNC; i++) begin
            res_mem[i] <= RES_S5;
         end
      end else if (reg_wr && reg_addr == ADDR_RES && reg_wdata[2:0] <= RES_S6) begin
         res_mem[meas_func] <= is_freqper(meas_func) ? rac_res_type'(reg_wdata[2:0] | 3'h1)
                                                     : rac_res_type'(reg_wdata[2:0]);
      end else if (btn_evt[1]) begin
         res_mem[meas_func] <= next_digits(res_cur, is_freqper(meas_func));
      end
   end

   assign filter_active_indicator = cfg_en;
   assign display_res  = res_cur;
   assign conv_res     = is_ac(meas_func) ? RES_S6 : res_cur;
   assign auto_zero_en = res_auto_zero(conv_res);
   assign nplc_sel     = res_nplc(conv_res);

   // Input FIFO
   rac_fifo #(.WIDTH(RD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (ref_clk),
      .resetn    (resetn),
      .in_valid  (rdg_valid),
      .in_ready  (rdg_ready),
      .in_data   (rdg_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready),
      .out_data  (fifo_data)
   );

   // Averaging buffer and running sum
   assign fifo_ready = (state == ST_IDLE);
   assign pop        = fifo_valid && fifo_ready;
   assign filter_active_indicator_on    = cfg_en && !is_bypass(meas_func);
   assign new_ext    = {{(SUM_W-RD_W){fifo_data[RD_W-1]}}, fifo_data};
   assign old_ext    = {{(SUM_W-RD_W){sample_buf[wr_idx][RD_W-1]}}, sample_buf[wr_idx]};
   assign div_start  = pop && filter_active_indicator_on && !clear_avg && (!cfg_mode || next_fill == cfg_count);

   always_comb begin
      if (fill == cfg_count) begin
         next_sum  = run_sum + new_ext - old_ext;
         next_fill = fill;
      end else begin
         next_sum  = run_sum + new_ext;
         next_fill = fill + 7'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (pop && filter_active_indicator_on) begin
         sample_buf[wr_idx] <= fifo_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn || clear_avg) begin
         fill    <= 7'h00;
         wr_idx  <= 7'h00;
         run_sum <= '0;
      end else if (pop && filter_active_indicator_on) begin
         if (cfg_mode && next_fill == cfg_count) begin
            fill    <= 7'h00;
            wr_idx  <= 7'h00;
            run_sum <= '0;
         end else begin
            fill    <= next_fill;
            wr_idx  <= (wr_idx == cfg_count - 7'h01) ? 7'h00 : wr_idx + 7'h01;
            run_sum <= next_sum;
         end
      end
   end

   // Sequential divide of the sum by the valid entry count
   always_ff @(posedge ref_clk) begin
      if (!resetn || clear_avg) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: if (div_start) state <= ST_DIV;
            ST_DIV:  if (div_step == DIV_LAST) state <= ST_IDLE;
         endcase
      end
   end

   assign rem_sh   = {div_rem[6:0], div_quo[SUM_W-1]};
   assign q_bit    = (rem_sh >= {1'b0, div_den});
   assign quo_fin  = {div_quo[SUM_W-2:0], q_bit};
   assign result   = div_neg ? (~quo_fin + 1'b1) : quo_fin;
   assign div_last = (state == ST_DIV) && (div_step == DIV_LAST);

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         div_quo  <= '0;
         div_rem  <= 8'h00;
         div_step <= 6'h00;
         div_den  <= 7'h01;
         div_neg  <= 1'b0;
      end else if (div_start) begin
         div_neg  <= next_sum[SUM_W-1];
         div_quo  <= next_sum[SUM_W-1] ? (~next_sum + 1'b1) : next_sum;
         div_rem  <= 8'h00;
         div_step <= 6'h00;
         div_den  <= next_fill;
      end else if (state == ST_DIV) begin
         div_rem  <= q_bit ? (rem_sh - {1'b0, div_den}) : rem_sh;
         div_quo  <= quo_fin;
         div_step <= div_step + 6'h01;
      end
   end

   // Display output
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         avg_valid <= 1'b0;
         avg_data  <= '0;
      end else begin
         avg_valid <= 1'b0;
         if (pop && !filter_active_indicator_on) begin
            avg_valid <= 1'b1;
            avg_data  <= fifo_data;
         end else if (div_last && !clear_avg) begin
            avg_valid <= 1'b1;
            avg_data  <= result[RD_W-1:0];
         end
      end
   end

   // Register reads
   always_comb begin
      read_word = 32'h0;
      case (reg_addr)
         ADDR_CTRL: begin
            read_word[CTRL_EN]       = cfg_en;
            read_word[CTRL_MODE]     = cfg_mode;
            read_word[CTRL_CNT +: 7] = cfg_count;
         end
         ADDR_ACBW: read_word[1:0] = ac_bw_sel;
         ADDR_FUNC: read_word[3:0] = meas_func;
         ADDR_RES:  read_word[2:0] = res_cur;
         ADDR_STAT: begin
            read_word[STAT_FILL +: 7] = fill;
            read_word[STAT_BUSY]      = (state == ST_DIV);
            read_word[STAT_CONV +: 3] = conv_res;
            read_word[STAT_AZ]        = auto_zero_en;
            read_word[STAT_NPLC +: 2] = nplc_sel;
         end
         default: read_word = 32'h0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         reg_rdata <= 32'h0;
      end else begin
         reg_rdata <= reg_rd ? read_word : 32'h0;
      end
   end

   // Checks
   // Marks a divide cut short by a clear, so its missing output is expected
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         div_cut <= 1'b0;
      end else if (clear_avg && state == ST_DIV) begin
         div_cut <= 1'b1;
      end else if (div_last) begin
         div_cut <= 1'b0;
      end
   end

   property p_count_range;
      cfg_count >= CNT_MIN && cfg_count <= CNT_MAX && fill <= cfg_count;
   endproperty
   a_count_range: assert property (p_count_range) else $error("window count out of range");

   property p_moving_full;
      pop && filter_active_indicator_on && !cfg_mode && !clear_avg && fill == cfg_count |=> fill == $past(fill) && state == ST_DIV;
   endproperty
   a_moving_full: assert property (p_moving_full) else $error("sliding mode full window changed");

   property p_block_flush;
      div_start && cfg_mode |=> fill == 7'h00 && run_sum == '0 ##32 (avg_valid || div_cut);
   endproperty
   a_block_flush: assert property (p_block_flush) else $error("block mode did not flush");

   property p_reset_defaults;
      $rose(resetn) |-> cfg_en && !cfg_mode && cfg_count == CNT_RST && ac_bw_sel == BW_MED;
   endproperty
   a_reset_defaults: assert property (@(posedge ref_clk) p_reset_defaults) else $error("bad reset defaults");

   property p_bypass;
      pop && is_bypass(meas_func) |=> avg_valid && avg_data == $past(fifo_data);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass reading not passed");

   property p_toggle;
      btn_evt[0] |=> cfg_en != $past(cfg_en) && filter_active_indicator == cfg_en;
   endproperty
   a_toggle: assert property (p_toggle) else $error("filter toggle failed");

   property p_bw_legal;
      ac_bw_sel != 2'h3;
   endproperty
   a_bw_legal: assert property (p_bw_legal) else $error("illegal bandwidth");

   property p_remote_reset;
      remote_reset |=> res_cur == RES_S5;
   endproperty
   a_remote_reset: assert property (p_remote_reset) else $error("resolution not defaulted");

   property p_ac_conv;
      is_ac(meas_func) |-> conv_res == RES_S6 && nplc_sel == NPLC_10 && display_res == res_cur;
   endproperty
   a_ac_conv: assert property (p_ac_conv) else $error("AC conversion not at full digits");

   property p_digits_step;
      btn_evt[1] && !remote_reset && !reg_wr && res_cur == RES_S4 |=> res_cur == RES_S5;
   endproperty
   a_digits_step: assert property (p_digits_step) else $error("digits step wrong");

   property p_fp_slow;
      is_freqper(meas_func) && $stable(meas_func) |-> res_cur[0];
   endproperty
   a_fp_slow: assert property (p_fp_slow) else $error("fast resolution on counter function");

   property p_fast4;
      conv_res == RES_F4 |-> !auto_zero_en && nplc_sel == NPLC_P02;
   endproperty
   a_fast4: assert property (p_fast4) else $error("fast 4.5 digit setting wrong");

   property p_clear;
      clear_avg |=> fill == 7'h00 && run_sum == '0 && state == ST_IDLE;
   endproperty
   a_clear: assert property (p_clear) else $error("averager not cleared");

   c_moving_out: cover property (div_last && !cfg_mode ##1 avg_valid);
   c_block_out: cover property (div_last && cfg_mode ##1 avg_valid);
   c_bypass: cover property (pop && !filter_active_indicator_on);
   c_fifo_full: cover property (!rdg_ready);
endmodule // rac_averager

`default_nettype wire

// ===== src/rac_pkg.sv
// Constants, types and decoders for the reading averager
// Function
// - Window count ranges 2 to 100 readings, kept in a buffer that deep.
// - Sliding mode: ring order, newest replaces oldest, average output on each reading.
// - Block mode: average once buffer holds count readings, then flush and restart.
// - After reset the filter is enabled, sliding mode, count ten.
// - Diode, continuity, frequency and period readings bypass the filter always.
// - Toggle control flips filter enable; indicator lit exactly while enabled.
// - AC bandwidth offers slow 3 Hz, medium 20 Hz, fast 200 Hz.
// - AC bandwidth resets to medium 20 Hz; held only in volatile state.
// - Six resolutions; default slow 5.5 digits after reset or remote reset.
// - Each function keeps its own resolution; changing one leaves others alone.
// - AC functions convert at 6.5 digits; lower choice only blanks displayed digits.
// - Digits press cycles slow 4.5, slow 5.5, fast 6.5 only (slow 6.5 for frequency and period).
// - Frequency and period accept only slow 4.5, 5.5, 6.5 resolutions.
// - Resolution sets auto-zero and integration time per the resolution table.
package rac_pkg;
   localparam int         RD_W       = 24;
   localparam int         SUM_W      = 32;
   localparam int         DEPTH      = 100;
   localparam int         FIFO_DEPTH = 4;
   localparam int         NFUNC      = 11;
   localparam logic [6:0] CNT_MIN    = 7'h02;
   localparam logic [6:0] CNT_MAX    = 7'h64;
   localparam logic [6:0] CNT_RST    = 7'h0A;
   localparam logic [5:0] DIV_LAST   = 6'h1F;
   // Register word indexes
   localparam logic [2:0] ADDR_CTRL  = 3'h0;
   localparam logic [2:0] ADDR_ACBW  = 3'h1;
   localparam logic [2:0] ADDR_FUNC  = 3'h2;
   localparam logic [2:0] ADDR_RES   = 3'h3;
   localparam logic [2:0] ADDR_STAT  = 3'h4;
   // Field positions
   localparam int         CTRL_EN    = 0;
   localparam int         CTRL_MODE  = 1;
   localparam int         CTRL_CNT   = 8;
   localparam int         STAT_FILL  = 0;
   localparam int         STAT_BUSY  = 8;
   localparam int         STAT_CONV  = 12;
   localparam int         STAT_AZ    = 16;
   localparam int         STAT_NPLC  = 20;

   typedef enum logic [1:0] {BW_SLOW = 2'h0, BW_MED = 2'h1, BW_FAST = 2'h2} rac_bw_type;
   typedef enum logic [2:0] {RES_F4 = 3'h0, RES_S4 = 3'h1, RES_F5 = 3'h2,
                             RES_S5 = 3'h3, RES_F6 = 3'h4, RES_S6 = 3'h5} rac_res_type;
   typedef enum logic [1:0] {NPLC_P02 = 2'h0, NPLC_P1 = 2'h1, NPLC_1 = 2'h2, NPLC_10 = 2'h3} rac_nplc_type;
   typedef enum logic [3:0] {FN_DCV = 4'h0, FN_ACV = 4'h1, FN_DCI = 4'h2, FN_ACI = 4'h3,
                             FN_RES2 = 4'h4, FN_RES4 = 4'h5, FN_FREQ = 4'h6, FN_PER = 4'h7,
                             FN_CONT = 4'h8, FN_DIODE = 4'h9, FN_TEMP = 4'hA} rac_func_type;
   typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_DIV = 2'h2} rac_state_type;

   function automatic logic is_ac(input rac_func_type f);
      return (f == FN_ACV) || (f == FN_ACI);
   endfunction

   function automatic logic is_freqper(input rac_func_type f);
      return (f == FN_FREQ) || (f == FN_PER);
   endfunction

   function automatic logic is_bypass(input rac_func_type f);
      return is_freqper(f) || (f == FN_CONT) || (f == FN_DIODE);
   endfunction

   function automatic rac_res_type next_digits(input rac_res_type r, input logic fp);
      case (r)
         RES_S4:  return RES_S5;
         RES_S5:  return fp ? RES_S6 : RES_F6;
         default: return RES_S4;
      endcase
   endfunction

   function automatic logic res_auto_zero(input rac_res_type r);
      return (r != RES_F4) && (r != RES_F5);
   endfunction

   function automatic rac_nplc_type res_nplc(input rac_res_type r);
      case (r)
         RES_F4:         return NPLC_P02;
         RES_S4, RES_F5: return NPLC_P1;
         RES_S5, RES_F6: return NPLC_1;
         default:        return NPLC_10;
      endcase
   endfunction

   function automatic logic [6:0] clamp_count(input logic [6:0] c);
      if (c < CNT_MIN) return CNT_MIN;
      if (c > CNT_MAX) return CNT_MAX;
      return c;
   endfunction
endpackage

// ===== testbench/rac_conv_model.sv
// Converter source and display sink facing the averager
`timescale 1ns/100ps
`default_nettype none

module rac_conv_model
   import rac_pkg::*;
(
   // Clock
   input  wire logic            ref_clk,
   // Converter side
   output logic                 rdg_valid,
   input  wire logic            rdg_ready,
   output logic      [RD_W-1:0] rdg_data,
   // Display side
   input  wire logic            avg_valid,
   input  wire logic [RD_W-1:0] avg_data
);
   logic [RD_W-1:0] shown[$];

   initial begin
      rdg_valid = 1'b0;
      rdg_data  = 24'h000000;
   end

   // Idle data keeps changing so stale values never look valid
   task automatic send(input logic [RD_W-1:0] d, input int gap);
      repeat (gap) @(posedge ref_clk) rdg_data <= ~rdg_data;
      @(posedge ref_clk);
      rdg_valid <= 1'b1;
      rdg_data  <= d;
      do @(posedge ref_clk); while (rdg_ready !== 1'b1);
      rdg_valid <= 1'b0;
      rdg_data  <= ~d;
   endtask

   always @(posedge ref_clk) begin
      if (avg_valid === 1'b1) begin
         shown.push_back(avg_data);
      end
   end
endmodule // rac_conv_model

`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the reading averager
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("wrong value %s %0h %0h", n, e, g); end end

module tb;
   import rac_pkg::*;
   logic            ref_clk, resetn, reg_wr, reg_rd, rdg_valid, rdg_ready, avg_valid;
   logic            filter_btn, digits_btn, remote_reset, filter_active_indicator;
   logic            auto_zero_en, saw_full;
   logic [2:0]      reg_addr;
   logic [31:0]     reg_wdata, reg_rdata, rd_v;
   logic [RD_W-1:0] rdg_data, avg_data;
   rac_bw_type      ac_bw_sel;
   rac_res_type     display_res, conv_res;
   rac_nplc_type    nplc_sel;
   int              errors, checks;
   logic [1:0]      npl [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
   logic [5:0]      azt = 6'h3A;
   rac_func_type    byp [4] = '{FN_FREQ, FN_PER, FN_CONT, FN_DIODE};
   rac_res_type     dseq [4] = '{RES_S4, RES_S5, RES_F6, RES_S4};

   rac_averager uut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rdg_valid(rdg_valid), .rdg_ready(rdg_ready),
      .rdg_data(rdg_data), .avg_valid(avg_valid), .avg_data(avg_data), .filter_btn(filter_btn),
      .digits_btn(digits_btn), .remote_reset(remote_reset), .filter_active_indicator(filter_active_indicator),
      .ac_bw_sel(ac_bw_sel), .display_res(display_res), .conv_res(conv_res), .auto_zero_en(auto_zero_en),
      .nplc_sel(nplc_sel));
   rac_conv_model conv (.ref_clk(ref_clk), .rdg_valid(rdg_valid), .rdg_ready(rdg_ready),
      .rdg_data(rdg_data), .avg_valid(avg_valid), .avg_data(avg_data));

   always #10 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      if (resetn !== 1'b1) begin
         saw_full <= 1'b0;
      end else if (rdg_valid === 1'b1 && rdg_ready === 1'b0) begin
         saw_full <= 1'b1;
      end
   end

   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rchk(input string n, input logic [2:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      rd_v = reg_rdata;
      `CHK(n, e, rd_v)
   endtask

   task automatic av(input logic [RD_W-1:0] e);
      logic [RD_W-1:0] g;
      for (int i = 0; i < 400 && conv.shown.size() == 0; i++) @(posedge ref_clk);
      g = (conv.shown.size() > 0) ? conv.shown.pop_front() : ~e;
      `CHK("avg_data", e, g)
   endtask

   task automatic press(input logic dig);
      @(posedge ref_clk);
      digits_btn <= dig;
      filter_btn <= ~dig;
      repeat (6) @(posedge ref_clk);
      digits_btn <= 1'b0;
      filter_btn <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
   endtask

   task automatic test_done;
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      test_done();
   end

   initial begin
      {ref_clk, resetn, reg_wr, reg_rd, filter_btn, digits_btn, remote_reset} = 7'h00;
      reg_addr  = 3'h0;
      reg_wdata = 32'h00000000;
      errors    = 0;
      checks    = 0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rchk("ctrl", ADDR_CTRL, 32'h00000A01);
      rchk("acbw", ADDR_ACBW, 32'h00000001);
      rchk("res", ADDR_RES, 32'h00000003);
      rchk("unmapped", 3'h7, 32'h00000000);
      `CHK("ind", 1'b1, filter_active_indicator)
      // Back-to-back readings fill the input FIFO while dividing, so readings are refused
      for (int k = 1; k <= 6; k++) conv.send(24'(10 * k), 0);
      for (int k = 1; k <= 6; k++) av(24'(5 * (k + 1)));
      `CHK("refused", 1'b1, saw_full)
      wr(ADDR_CTRL, 32'h00000101);
      rchk("cnt_lo", ADDR_CTRL, 32'h00000201);
      wr(ADDR_CTRL, 32'h00006501);
      rchk("cnt_hi", ADDR_CTRL, 32'h00006401);
      // Window of two: oldest reading drops out
      wr(ADDR_CTRL, 32'h00000201);
      for (int k = 1; k <= 3; k++) conv.send(24'(2 * k), k);
      av(24'h000002);
      av(24'h000003);
      av(24'h000005);
      wr(ADDR_CTRL, 32'h00000203);
      conv.send(24'hFFFFFD, 0);
      conv.send(24'hFFFFFC, 0);
      conv.send(24'h000008, 2);
      conv.send(24'h00000A, 0);
      av(24'hFFFFFD);
      av(24'h000009);
      repeat (80) @(posedge ref_clk);
      `CHK("extra", 0, conv.shown.size())
      press(1'b0);
      `CHK("ind_off", 1'b0, filter_active_indicator)
      rchk("ctrl_off", ADDR_CTRL, 32'h00000202);
      conv.send(24'h000007, 2);
      av(24'h000007);
      press(1'b0);
      `CHK("ind_on", 1'b1, filter_active_indicator)
      foreach (byp[i]) begin
         wr(ADDR_FUNC, {28'h0000000, byp[i]});
         conv.send(24'(i + 20), 1);
         av(24'(i + 20));
      end
      for (int b = 0; b < 3; b++) begin
         wr(ADDR_ACBW, 32'(b));
         `CHK("bw_pin", 2'(b), ac_bw_sel)
      end
      wr(ADDR_ACBW, 32'h00000003);
      rchk("acbw_bad", ADDR_ACBW, 32'h00000002);
      wr(ADDR_FUNC, 32'h00000000);
      for (int r = 0; r < 6; r++) begin
         wr(ADDR_RES, 32'(r));
         `CHK("res_pin", 3'(r), display_res)
         `CHK("az", azt[r], auto_zero_en)
         `CHK("nplc", npl[r], nplc_sel)
      end
      wr(ADDR_FUNC, 32'h00000002);
      `CHK("res_dci", RES_S5, display_res)
      wr(ADDR_RES, 32'h00000001);
      wr(ADDR_FUNC, 32'h00000000);
      `CHK("res_dcv", RES_S6, display_res)
      for (int p = 0; p < 4; p++) begin
         press(1'b1);
         `CHK("digits", dseq[p], display_res)
      end
      wr(ADDR_FUNC, 32'h00000001);
      wr(ADDR_RES, 32'h00000001);
      `CHK("ac_disp", RES_S4, display_res)
      `CHK("ac_conv", RES_S6, conv_res)
      rchk("stat", ADDR_STAT, 32'h00315000);
      wr(ADDR_FUNC, 32'h00000006);
      wr(ADDR_RES, 32'h00000004);
      `CHK("fp_res", RES_S6, display_res)
      @(posedge ref_clk);
      remote_reset <= 1'b1;
      @(posedge ref_clk);
      remote_reset <= 1'b0;
      #1;
      `CHK("rr_fp", RES_S5, display_res)
      wr(ADDR_FUNC, 32'h00000002);
      `CHK("rr_dci", RES_S5, display_res)
      test_done();
   end
endmodule // tb

`default_nettype wire
